// ### tadc_defines.svh
/*
  Constants of the touch digitizer serial control: word lengths, edge counts and reset values.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef TADC_DEFINES_SVH
`define TADC_DEFINES_SVH

`define TADC_CTRL_BITS 8
`define TADC_RESULT_BITS 12
`define TADC_ACQ_START_FALL 5'h05
`define TADC_ACQ_CYCLES 5'h03
`define TADC_FALL_MAX 5'h1F
`define TADC_FIFO_DEPTH 8
`define TADC_CTRL_RESET 8'h00

`endif

// ### tadc_pkg.sv
/*
  Types of the touch digitizer serial control: sequence states and the packed state record.
  Assumes tadc_defines.svh is on the include path.
*/
`default_nettype none
`include "tadc_defines.svh"

package tadc_pkg;

  typedef enum logic [2:0] {
    TADC_IDLE,
    TADC_CMD,
    TADC_ACQ,
    TADC_CONV,
    TADC_OUT
  } tadc_state_e;

  typedef struct packed {
    tadc_state_e state;
    logic sclk_prev;
    logic [`TADC_CTRL_BITS-1:0] ctrl;
    logic [3:0] bit_cnt;
    logic [4:0] fall_cnt;
    logic [`TADC_RESULT_BITS-1:0] shreg;
    logic dout;
    logic dout_oe;
    logic busy;
    logic busy_oe;
    logic tracking;
    logic irq_oe;
    logic irq_level;
  } tadc_state_s;

endpackage

`default_nettype wire

// ### tadc_serial_control.sv
/*
  Serial control of a touch screen digitizer: command shift-in, acquisition and conversion
  sequencing, result shift-out, busy and pen-touch indication, and a sample FIFO.
  Assumes one 125 MHz clock; chip select, serial clock, serial input and the converter sample
  stream are synchronous to it. Tri-state and open-drain pins are resolved outside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tadc_defines.svh"

module tadc_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic ready;
  } tadc_fifo_s;

  logic [WIDTH-1:0] mem [DEPTH];
  tadc_fifo_s s_q;
  tadc_fifo_s s_d;
  logic push;
  logic pop;

  assign push = in_valid && s_q.ready;
  assign pop = out_ready && (s_q.count != '0);
  assign in_ready = s_q.ready;
  assign out_valid = (s_q.count != '0);
  assign out_data = mem[s_q.rd_ptr];

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.wr_ptr = (s_q.wr_ptr == AW'(DEPTH - 1)) ? '0 : s_q.wr_ptr + 1'b1;
    end
    if (pop) begin
      s_d.rd_ptr = (s_q.rd_ptr == AW'(DEPTH - 1)) ? '0 : s_q.rd_ptr + 1'b1;
    end
    s_d.count = s_q.count + CW'(push) - CW'(pop);
    s_d.ready = (s_d.count < CW'(DEPTH));
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s_q <= '{wr_ptr: '0, rd_ptr: '0, count: '0, ready: 1'b1};
    end else begin
      s_q <= s_d;
    end
    if (push) begin
      mem[s_q.wr_ptr] <= in_data;
    end
  end
endmodule

module tadc_serial_control #(
  parameter int FIFO_DEPTH = `TADC_FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic cs_n,
  input wire logic shift_conv_clock,
  input wire logic din,
  output logic dout_o,
  output logic dout_oe,
  output logic busy_o,
  output logic busy_oe,
  input wire logic pen_touch_det,
  output logic pen_touch_irq_n_o,
  output logic pen_touch_irq_n_oe,
  output logic tracking,
  output logic [`TADC_CTRL_BITS-1:0] ctrl_word,
  input wire logic [`TADC_RESULT_BITS-1:0] sample_data,
  input wire logic sample_valid,
  output logic sample_ready
);
  import tadc_pkg::*;

  tadc_state_s s_q;
  tadc_state_s s_d;
  logic rise;
  logic fall;
  logic pop;
  logic [`TADC_RESULT_BITS-1:0] fifo_data;
  logic fifo_valid;
  logic fifo_ready;

  tadc_fifo #(.WIDTH(`TADC_RESULT_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .srst(srst),
    .in_data(sample_data),
    .in_valid(sample_valid),
    .in_ready(fifo_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(pop)
  );

  // Serial clock edges are found against the level sampled one clock earlier.
  assign rise = shift_conv_clock && !s_q.sclk_prev;
  assign fall = !shift_conv_clock && s_q.sclk_prev;

  always_comb begin
    s_d = s_q;
    pop = 1'b0;
    s_d.sclk_prev = shift_conv_clock;
    s_d.irq_level = 1'b0;
    s_d.irq_oe = pen_touch_det;
    s_d.dout_oe = !cs_n;
    s_d.busy_oe = !cs_n;
    // A high chip select abandons any sequence and releases both outputs.
    if (cs_n) begin
      s_d.state = TADC_IDLE;
      s_d.busy = 1'b0;
      s_d.dout = 1'b0;
      s_d.tracking = 1'b0;
      s_d.bit_cnt = '0;
      s_d.fall_cnt = '0;
    end else begin
      if (rise) begin
        if ((s_q.state == TADC_IDLE || s_q.state == TADC_OUT) && din) begin
          s_d.state = TADC_CMD;
          s_d.ctrl = {s_q.ctrl[`TADC_CTRL_BITS-2:0], din};
          s_d.bit_cnt = 4'h1;
          s_d.fall_cnt = '0;
        end else if (s_q.bit_cnt != '0 && s_q.bit_cnt < 4'(`TADC_CTRL_BITS)) begin
          s_d.ctrl = {s_q.ctrl[`TADC_CTRL_BITS-2:0], din};
          s_d.bit_cnt = s_q.bit_cnt + 4'h1;
        end
      end
      if (fall && s_q.state != TADC_IDLE) begin
        if (s_q.fall_cnt != `TADC_FALL_MAX) begin
          s_d.fall_cnt = s_q.fall_cnt + 5'h01;
        end
        // Falls are counted from the first fall after the start bit.
        case (s_q.state)
          TADC_CMD: begin
            if (s_d.fall_cnt == `TADC_ACQ_START_FALL) begin
              s_d.state = TADC_ACQ;
              s_d.tracking = 1'b1;
            end
          end
          TADC_ACQ: begin
            if (s_d.fall_cnt == `TADC_ACQ_START_FALL + `TADC_ACQ_CYCLES) begin
              s_d.state = TADC_CONV;
              s_d.tracking = 1'b0;
              s_d.busy = 1'b1;
              s_d.shreg = fifo_valid ? fifo_data : '0;
              pop = fifo_valid;
              s_d.bit_cnt = '0;
            end
          end
          TADC_CONV: begin
            s_d.state = TADC_OUT;
            s_d.busy = 1'b0;
            s_d.dout = s_q.shreg[`TADC_RESULT_BITS-1];
            s_d.shreg = {s_q.shreg[`TADC_RESULT_BITS-2:0], 1'b0};
          end
          TADC_OUT: begin
            s_d.dout = s_q.shreg[`TADC_RESULT_BITS-1];
            s_d.shreg = {s_q.shreg[`TADC_RESULT_BITS-2:0], 1'b0};
          end
          default: begin
            s_d.state = TADC_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s_q <= '{state: TADC_IDLE, sclk_prev: 1'b0, ctrl: `TADC_CTRL_RESET, bit_cnt: '0,
               fall_cnt: '0, shreg: '0, dout: 1'b0, dout_oe: 1'b0, busy: 1'b0,
               busy_oe: 1'b0, tracking: 1'b0, irq_oe: 1'b0, irq_level: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // Ready is the FIFO's own registered flag, so an offered word is never dropped.
  assign sample_ready = fifo_ready;

  assign dout_o = s_q.dout;
  assign dout_oe = s_q.dout_oe;
  assign busy_o = s_q.busy;
  assign busy_oe = s_q.busy_oe;
  assign pen_touch_irq_n_o = s_q.irq_level;
  assign pen_touch_irq_n_oe = s_q.irq_oe;
  assign tracking = s_q.tracking;
  assign ctrl_word = s_q.ctrl;
endmodule

`default_nettype wire

// ### tadc_host_model.sv
/* Host model driving 24-clock frames on the digitizer serial link.
   Assumes the bench system clock; drives on its falling edge. */
`timescale 1ns/1ps
`default_nettype none
module tadc_host_model (
  input wire logic clock,
  output logic cs_n,
  output logic shift_conv_clock,
  output logic din,
  input wire logic dout_o,
  input wire logic dout_oe,
  input wire logic tracking
);
  logic line_q = 1'b0;
  logic [23:0] cap;
  initial begin
    cs_n = 1'b1;
    shift_conv_clock = 1'b0;
    din = 1'b0;
  end
  // A released data line shows a toggling pattern.
  always @(posedge clock) line_q <= dout_oe ? dout_o : ~line_q;
  task automatic frame(input logic [7:0] cmd, output logic [14:0] res, output int trk);
    int i;
    trk = 0;
    @(negedge clock) cs_n = 1'b0;
    for (i = 0; i < 24; i++) begin
      din = (i < 8) ? cmd[7-i] : 1'b0;
      repeat (4) @(negedge clock);
      shift_conv_clock = 1'b1;
      cap = {cap[22:0], line_q};
      repeat (4) @(negedge clock);
      shift_conv_clock = 1'b0;
      if (trk == 0 && tracking === 1'b1) trk = i;
    end
    repeat (4) @(negedge clock);
    cs_n = 1'b1;
    res = cap[14:0];
  endtask
endmodule
`default_nettype wire

// ### tadc_serial_control_sva.sv
/* Port checker of the digitizer serial control.
   Assumes binding into tadc_serial_control. */
`timescale 1ns/1ps
`default_nettype none
module tadc_serial_control_sva (
  input wire logic clock,
  input wire logic srst,
  input wire logic cs_n,
  input wire logic shift_conv_clock,
  input wire logic dout_o,
  input wire logic dout_oe,
  input wire logic busy_o,
  input wire logic busy_oe,
  input wire logic pen_touch_det,
  input wire logic pen_touch_irq_n_o,
  input wire logic pen_touch_irq_n_oe,
  input wire logic tracking
);
  logic [3:0] nf_q;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  always_ff @(posedge clock) begin
    if (srst || !tracking) nf_q <= 4'h0;
    else if ($past(shift_conv_clock) && !shift_conv_clock) nf_q <= nf_q + 4'h1;
  end
  property p_dout_oe; $past(!srst) |-> dout_oe == !$past(cs_n); endproperty
  a_dout_oe: assert property (p_dout_oe) else $error("dout enable");
  property p_busy_oe; $past(!srst) |-> busy_oe == !$past(cs_n); endproperty
  a_busy_oe: assert property (p_busy_oe) else $error("busy enable");
  property p_irq_low; pen_touch_irq_n_o == 1'b0; endproperty
  a_irq_low: assert property (p_irq_low) else $error("irq level");
  property p_irq_oe; $past(!srst) |-> pen_touch_irq_n_oe == $past(pen_touch_det); endproperty
  a_irq_oe: assert property (p_irq_oe) else $error("irq enable");
  property p_dout_fall;
    $changed(dout_o) && !cs_n && !$past(cs_n) && !$past(cs_n, 2) |->
      $past(shift_conv_clock, 2) && !$past(shift_conv_clock);
  endproperty
  a_dout_fall: assert property (p_dout_fall) else $error("dout moved off a fall");
  property p_trk_fall; $rose(tracking) |-> $past(shift_conv_clock, 2) && !$past(shift_conv_clock); endproperty
  a_trk_fall: assert property (p_trk_fall) else $error("tracking start");
  property p_trk_len; $fell(tracking) && !$past(cs_n) |-> nf_q == 4'h3; endproperty
  a_trk_len: assert property (p_trk_len) else $error("tracking length");
  property p_busy; $rose(busy_o) |-> $fell(tracking); endproperty
  a_busy: assert property (p_busy) else $error("busy start");
  property p_abort; cs_n && $past(cs_n) |-> !tracking && !busy_o; endproperty
  a_abort: assert property (p_abort) else $error("abort");
endmodule
bind tadc_serial_control tadc_serial_control_sva u_sva (.clock, .srst, .cs_n, .shift_conv_clock, .dout_o,
  .dout_oe, .busy_o, .busy_oe, .pen_touch_det, .pen_touch_irq_n_o, .pen_touch_irq_n_oe, .tracking);
`default_nettype wire

// ### tadc_serial_control_tb.sv
/* Bench of the digitizer serial control: frame table, then fill, drain, pen and abort cases.
   Assumes the host model and checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tadc_serial_control_tb;
  import tadc_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic cs_n, shift_conv_clock, din, dout_o, dout_oe, busy_o, busy_oe, tracking, sample_ready;
  logic pen_touch_irq_n_o, pen_touch_irq_n_oe;
  logic pen_touch_det = 1'b0;
  logic sample_valid = 1'b0;
  logic [11:0] sample_data = 12'h000;
  logic [7:0] ctrl_word;
  logic [14:0] res;
  int trk, i;
  int fail_count = 0;
  int compares = 0;
  int busy_cnt = 0;
  logic [19:0] rows [4] = '{20'h80000, 20'hFFFFF, 20'hC5A5C, 20'hB3801};
  always #4 clock = ~clock;
  always @(negedge clock) if (busy_o === 1'b1) busy_cnt++;
  tadc_serial_control #(.FIFO_DEPTH(8)) DUT (.clock, .srst, .cs_n, .shift_conv_clock, .din, .dout_o,
    .dout_oe, .busy_o, .busy_oe, .pen_touch_det, .pen_touch_irq_n_o, .pen_touch_irq_n_oe, .tracking,
    .ctrl_word, .sample_data, .sample_valid, .sample_ready);
  tadc_host_model host (.clock, .cs_n, .shift_conv_clock, .din, .dout_o, .dout_oe, .tracking);
  task automatic complete_run;
    if (fail_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string name, input logic [14:0] seen, input logic [14:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic push(input logic [11:0] v);
    @(negedge clock);
    sample_data = v;
    sample_valid = sample_ready;
    @(negedge clock);
    sample_valid = 1'b0;
    @(negedge clock);
  endtask
  task automatic run(input logic [7:0] cmd, input logic [11:0] v);
    int b0;
    b0 = busy_cnt;
    host.frame(cmd, res, trk);
    check("busy", 15'(busy_cnt - b0), 15'h0008);
    check("result", res, {v, 3'b000});
    check("ctrl", 15'(ctrl_word), 15'(cmd));
    check("track", 15'(trk), 15'h0005);
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    complete_run;
  end
  initial begin
    repeat (8) @(posedge clock);
    @(negedge clock);
    srst = 1'b0;
    check("dout_oe", 15'(dout_oe), 15'h0000);
    for (i = 0; i < 4; i++) begin
      push(rows[i][11:0]);
      run(rows[i][19:12], rows[i][11:0]);
    end
    for (i = 0; i < 9; i++) push(12'h100 + 12'(i));
    check("full", 15'(sample_ready), 15'h0000);
    for (i = 0; i < 8; i++) run(8'h87, 12'h100 + 12'(i));
    run(8'h87, 12'h000);
    pen_touch_det = 1'b1;
    repeat (2) @(negedge clock);
    check("irq_oe", 15'(pen_touch_irq_n_oe), 15'h0001);
    check("irq_lvl", 15'(pen_touch_irq_n_o), 15'h0000);
    pen_touch_det = 1'b0;
    repeat (2) @(negedge clock);
    check("irq_off", 15'(pen_touch_irq_n_oe), 15'h0000);
    fork
      host.frame(8'h87, res, trk);
      begin
        repeat (50) @(negedge clock);
        host.cs_n = 1'b1;
        repeat (2) @(negedge clock);
        check("abort", {12'h000, tracking, dout_oe, busy_oe}, 15'h0000);
      end
    join
    push(12'h3C3);
    srst = 1'b1;
    repeat (8) @(negedge clock);
    srst = 1'b0;
    check("rst_ctrl", 15'(ctrl_word), 15'h0000);
    run(8'h87, 12'h000);
    complete_run;
  end
endmodule
`default_nettype wire
